//--- src/lfda_top.sv
// fault detection, flag aggregation and output gating of the led driver
// How it works
// - error pin pulled low while any fault flag is set
// - resistor diagnosis 00 or 11 counts as a fault
// - distinct read commands return each fault group
// - rail short checked only when lit, unmasked, both masks set, lit over 5 us
// - rail short result set on comparator abnormality, else stays normal
// - any rail short result sets the combined short flag
// - rail results and short flag returned by their read commands
// - results and flags hold until reset-status command
// - per-channel rail short mask zero disables that channel
// - ground short checked when both masks set and unlit over 5 us
// - ground short result set when output below open threshold
// - any ground short result sets combined short flag
// - ground short results returned by their read command
// - lit for duty plus one of 1024 frame steps
// - select codes 1..6 pick generators, code 0 keeps output on
// - masked output stays off
`timescale 1ns/1ps
`include "lfda_regs.svh"
module lfda_top (
  input wire logic clk_i, // 10 MHz clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic clk_en_i, // freezes state while low
  input wire lfda_pkg::lfda_mask_t masks_i, // output and detection masks
  input wire lfda_pkg::lfda_pwm_cfg_t pwm_cfg_i, // channel select and duty words
  input wire logic [`LFDA_NCH-1:0] rail_cmp_i, // sense minus output below short threshold
  input wire logic [`LFDA_NCH-1:0] gnd_cmp_i, // output below open threshold
  input wire logic [`LFDA_NCH-1:0] open_result_i, // open results from open detector
  input wire logic [`LFDA_NCH-1:0] adjacent_result_i, // results from adjacent detector
  input wire lfda_pkg::lfda_fault_in_t fault_i, // other monitors' fault levels
  input wire lfda_pkg::lfda_cmd_req_t cmd_i, // decoded serial command
  output logic [`LFDA_NCH-1:0] led_on_o, // output driver on
  output logic rd_valid_o, // read answer pulse
  output logic [`LFDA_RD_W-1:0] rd_data_o, // read answer word
  output logic err_o, // error pin drive level, always low
  output logic err_oe_o // error pin pulled low
);

  logic [`LFDA_NPWM-1:0] pwm_lit;
  logic [`LFDA_NCH-1:0] led_on_d, led_on_q;
  logic [`LFDA_NCH-1:0][`LFDA_CNT_W-1:0] phase_cnt_q;
  logic [`LFDA_NCH-1:0] qual;
  logic [`LFDA_NCH-1:0] rail_hit, gnd_hit;
  logic [`LFDA_NCH-1:0] rail_res_q, gnd_res_q;
  logic any_short_q, overtemp_warn_flag_q, any_open_flag_q, any_adjacent_flag_q;
  logic supply_abnormal_flag_q, clock_fault_flag_q, reset_event_q;
  logic [`LFDA_IR_W-1:0] ref_diag_q;
  logic ref_bad;
  logic clr;
  logic [`LFDA_RD_W-1:0] status_word;
  logic [`LFDA_RD_W-1:0] rd_data_d;
  logic err_lvl_q, err_oe_q, rd_valid_q;
  logic [`LFDA_RD_W-1:0] rd_data_q;

  // channel on level from its select code and the generator outputs
  function automatic logic chan_lit(input logic [`LFDA_SEL_W-1:0] sel,
                                    input logic [`LFDA_NPWM-1:0] lit);
    logic [`LFDA_SEL_W-1:0] idx;
    idx = sel - `LFDA_SEL_FIRST;
    if (sel == `LFDA_SEL_ON)
      chan_lit = 1'b1;
    else if (sel <= `LFDA_SEL_LAST)
      chan_lit = lit[idx];
    else
      chan_lit = 1'b0;
  endfunction

  function automatic logic ir_fault(input logic [`LFDA_IR_W-1:0] d);
    ir_fault = (d == `LFDA_IR_BAD_LO) || (d == `LFDA_IR_BAD_HI);
  endfunction

  lfda_pwm u_pwm (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .duty_i(pwm_cfg_i.duty),
    .lit_o(pwm_lit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output switching
  always_comb
  begin
    for (int c = 0; c < `LFDA_NCH; c++)
      led_on_d[c] = masks_i.out_en[c] && chan_lit(pwm_cfg_i.sel[c], pwm_lit);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      led_on_q <= `LFDA_CH_ZERO;
    else if (clk_en_i)
      led_on_q <= led_on_d;
  end

  // cycles the present lit or unlit phase has lasted, saturating
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      phase_cnt_q <= '0;
    else if (clk_en_i)
    begin
      for (int c = 0; c < `LFDA_NCH; c++)
      begin
        if (led_on_d[c] != led_on_q[c])
          phase_cnt_q[c] <= `LFDA_CNT_ZERO;
        else if (phase_cnt_q[c] != `LFDA_CNT_W'(`LFDA_QUAL_CYC))
          phase_cnt_q[c] <= phase_cnt_q[c] + `LFDA_CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection windows and comparator sampling
  always_comb
  begin
    for (int c = 0; c < `LFDA_NCH; c++)
    begin
      qual[c] = (phase_cnt_q[c] == `LFDA_CNT_W'(`LFDA_QUAL_CYC));
      rail_hit[c] = qual[c] && led_on_q[c] && masks_i.out_en[c] && masks_i.rail_chan[c]
                    && masks_i.rail_glob && rail_cmp_i[c];
      gnd_hit[c] = qual[c] && !led_on_q[c] && masks_i.gnd_chan[c]
                   && masks_i.gnd_glob && gnd_cmp_i[c];
    end
  end

  assign clr = cmd_i.valid && (cmd_i.code == lfda_pkg::LFDA_CLR_STATUS);

  // sticky results; a new abnormality wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rail_res_q <= `LFDA_CH_ZERO;
      gnd_res_q <= `LFDA_CH_ZERO;
    end
    else if (clk_en_i)
    begin
      rail_res_q <= (rail_res_q & ~{`LFDA_NCH{clr}}) | rail_hit;
      gnd_res_q <= (gnd_res_q & ~{`LFDA_NCH{clr}}) | gnd_hit;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      any_short_q <= 1'b0;
      overtemp_warn_flag_q <= 1'b0;
      any_open_flag_q <= 1'b0;
      any_adjacent_flag_q <= 1'b0;
      supply_abnormal_flag_q <= 1'b0;
      clock_fault_flag_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      any_short_q <= (any_short_q && !clr) || (|rail_hit) || (|gnd_hit);
      overtemp_warn_flag_q <= (overtemp_warn_flag_q && !clr) || fault_i.overtemp;
      any_open_flag_q <= (any_open_flag_q && !clr) || fault_i.open;
      any_adjacent_flag_q <= (any_adjacent_flag_q && !clr) || fault_i.adjacent;
      supply_abnormal_flag_q <= (supply_abnormal_flag_q && !clr) || fault_i.supply;
      clock_fault_flag_q <= (clock_fault_flag_q && !clr) || fault_i.clock;
    end
  end

  // reset event stays up until software clears the flags
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reset_event_q <= 1'b1;
    else if (clk_en_i && clr)
      reset_event_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ref_diag_q <= `LFDA_IR_RST;
    else if (clk_en_i)
      ref_diag_q <= fault_i.ref_diag;
  end

  assign ref_bad = ir_fault(ref_diag_q);

  ////////////////////////////////////////////////////////////////////////////
  // error pin, open drain
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      err_oe_q <= 1'b1;
    else if (clk_en_i)
      err_oe_q <= overtemp_warn_flag_q || any_short_q || any_open_flag_q
                  || any_adjacent_flag_q || supply_abnormal_flag_q || ref_bad
                  || clock_fault_flag_q || reset_event_q;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      err_lvl_q <= 1'b0;
    else
      err_lvl_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read commands
  always_comb
  begin
    status_word = `LFDA_RD_ZERO;
    status_word[`LFDA_ST_OVT] = overtemp_warn_flag_q;
    status_word[`LFDA_ST_SHORT] = any_short_q;
    status_word[`LFDA_ST_OPEN] = any_open_flag_q;
    status_word[`LFDA_ST_ADJ] = any_adjacent_flag_q;
    status_word[`LFDA_ST_SUPPLY] = supply_abnormal_flag_q;
    status_word[`LFDA_ST_CLOCK] = clock_fault_flag_q;
    status_word[`LFDA_ST_RESET] = reset_event_q;
  end

  always_comb
  begin
    case (cmd_i.code)
      lfda_pkg::LFDA_RD_STATUS: rd_data_d = status_word;
      lfda_pkg::LFDA_RD_CURRENT_REFERENCE_PIN: rd_data_d = `LFDA_RD_W'(ref_diag_q);
      lfda_pkg::LFDA_RD_RAIL: rd_data_d = rail_res_q;
      lfda_pkg::LFDA_RD_GND: rd_data_d = gnd_res_q;
      lfda_pkg::LFDA_RD_OPEN: rd_data_d = open_result_i;
      lfda_pkg::LFDA_RD_ADJ: rd_data_d = adjacent_result_i;
      default: rd_data_d = `LFDA_RD_ZERO;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q <= `LFDA_RD_ZERO;
    end
    else if (clk_en_i)
    begin
      rd_valid_q <= cmd_i.valid && !clr;
      if (cmd_i.valid && !clr)
        rd_data_q <= rd_data_d;
    end
  end

  assign led_on_o = led_on_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_data_o = rd_data_q;
  assign err_o = err_lvl_q;
  assign err_oe_o = err_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_rail_read;
    clk_en_i && cmd_i.valid && cmd_i.code == lfda_pkg::LFDA_RD_RAIL;
  endsequence

  sequence s_gnd_read;
    clk_en_i && cmd_i.valid && cmd_i.code == lfda_pkg::LFDA_RD_GND;
  endsequence

  property p_fault_err;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && (any_short_q || any_open_flag_q || clock_fault_flag_q)) |=> err_oe_o;
  endproperty
  a_fault_err: assert property (p_fault_err)
    else $error("fault flagged but error pin released");

  property p_ref_err;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && (ref_diag_q == `LFDA_IR_BAD_LO || ref_diag_q == `LFDA_IR_BAD_HI))
      |=> err_oe_o;
  endproperty
  a_ref_err: assert property (p_ref_err)
    else $error("resistor diagnosis fault missed");

  property p_rail_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_rail_read |=> rd_valid_o && rd_data_o == $past(rail_res_q);
  endproperty
  a_rail_read: assert property (p_rail_read)
    else $error("rail short read returned wrong word");

  property p_gnd_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    s_gnd_read |=> rd_valid_o && rd_data_o == $past(gnd_res_q);
  endproperty
  a_gnd_read: assert property (p_gnd_read)
    else $error("ground short read returned wrong word");

  property p_rail_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && |rail_hit) |=> ((rail_res_q & $past(rail_hit)) == $past(rail_hit))
      && any_short_q;
  endproperty
  a_rail_set: assert property (p_rail_set)
    else $error("rail short abnormality not recorded");

  property p_gnd_set;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && |gnd_hit) |=> ((gnd_res_q & $past(gnd_hit)) == $past(gnd_hit))
      && any_short_q;
  endproperty
  a_gnd_set: assert property (p_gnd_set)
    else $error("ground short abnormality not recorded");

  property p_short_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && any_short_q && !clr) |=> any_short_q;
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("short flag dropped without clear");

  property p_mask_off;
    @(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i |=> (led_on_o & ~$past(masks_i.out_en)) == `LFDA_CH_ZERO;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("masked output switched on");

  property p_rail_masked;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && !masks_i.rail_glob && !clr && rail_res_q == `LFDA_CH_ZERO)
      |=> rail_res_q == `LFDA_CH_ZERO;
  endproperty
  a_rail_masked: assert property (p_rail_masked)
    else $error("rail short set while globally masked");

  property p_reset_err;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && reset_event_q) |=> err_oe_o;
  endproperty
  a_reset_err: assert property (p_reset_err)
    else $error("reset event not shown on error pin");
endmodule

//--- src/lfda_regs.svh
// constants of the led fault detect and aggregate block
`ifndef LFDA_REGS_SVH
`define LFDA_REGS_SVH

`define LFDA_NCH 12
`define LFDA_NPWM 6
`define LFDA_PWM_W 10
`define LFDA_PWM_MAX 10'h3FF
`define LFDA_PWM_ZERO 10'h000
`define LFDA_PWM_ONE 10'h001
`define LFDA_SEL_W 3
`define LFDA_SEL_ON 3'h0
`define LFDA_SEL_FIRST 3'h1
`define LFDA_SEL_LAST 3'h6

`define LFDA_CLK_NS 100
`define LFDA_QUAL_NS 5000
`define LFDA_QUAL_CYC ((`LFDA_QUAL_NS + `LFDA_CLK_NS - 1) / `LFDA_CLK_NS)
`define LFDA_CNT_W 6
`define LFDA_CNT_ZERO 6'h00
`define LFDA_CNT_ONE 6'h01

`define LFDA_CMD_W 3
`define LFDA_CMD_RD_STATUS 3'h0
`define LFDA_CMD_RD_CURRENT_REFERENCE_PIN 3'h1
`define LFDA_CMD_RD_RAIL 3'h2
`define LFDA_CMD_RD_GND 3'h3
`define LFDA_CMD_RD_OPEN 3'h4
`define LFDA_CMD_RD_ADJ 3'h5
`define LFDA_CMD_CLR_STATUS 3'h6

`define LFDA_RD_W 12
`define LFDA_RD_ZERO 12'h000
`define LFDA_CH_ZERO 12'h000
`define LFDA_ST_OVT 0
`define LFDA_ST_SHORT 1
`define LFDA_ST_OPEN 2
`define LFDA_ST_ADJ 3
`define LFDA_ST_SUPPLY 4
`define LFDA_ST_CLOCK 5
`define LFDA_ST_RESET 6
`define LFDA_ST_PAD 5'h00

`define LFDA_IR_W 2
`define LFDA_IR_BAD_LO 2'h0
`define LFDA_IR_BAD_HI 2'h3
`define LFDA_IR_RST 2'h1

`endif

//--- src/lfda_pkg.sv
// types shared by the led fault detect and aggregate block
package lfda_pkg;
`include "lfda_regs.svh"

  typedef enum logic [`LFDA_CMD_W-1:0] {
    LFDA_RD_STATUS = `LFDA_CMD_RD_STATUS,
    LFDA_RD_CURRENT_REFERENCE_PIN = `LFDA_CMD_RD_CURRENT_REFERENCE_PIN,
    LFDA_RD_RAIL = `LFDA_CMD_RD_RAIL,
    LFDA_RD_GND = `LFDA_CMD_RD_GND,
    LFDA_RD_OPEN = `LFDA_CMD_RD_OPEN,
    LFDA_RD_ADJ = `LFDA_CMD_RD_ADJ,
    LFDA_CLR_STATUS = `LFDA_CMD_CLR_STATUS
  } lfda_cmd_t;

  typedef struct packed {
    logic [`LFDA_NCH-1:0] out_en;
    logic [`LFDA_NCH-1:0] rail_chan;
    logic rail_glob;
    logic [`LFDA_NCH-1:0] gnd_chan;
    logic gnd_glob;
  } lfda_mask_t;

  typedef struct packed {
    logic [`LFDA_NCH-1:0][`LFDA_SEL_W-1:0] sel;
    logic [`LFDA_NPWM-1:0][`LFDA_PWM_W-1:0] duty;
  } lfda_pwm_cfg_t;

  typedef struct packed {
    logic overtemp;
    logic open;
    logic adjacent;
    logic supply;
    logic clock;
    logic [`LFDA_IR_W-1:0] ref_diag;
  } lfda_fault_in_t;

  typedef struct packed {
    logic valid;
    lfda_cmd_t code;
  } lfda_cmd_req_t;
endpackage

//--- src/lfda_pwm.sv
// six pwm generators sharing one 1024-step frame counter
`timescale 1ns/1ps
`include "lfda_regs.svh"
module lfda_pwm (
  input wire logic clk_i, // 10 MHz clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic clk_en_i, // freezes state while low
  input wire logic [`LFDA_NPWM-1:0][`LFDA_PWM_W-1:0] duty_i, // duty word per generator
  output logic [`LFDA_NPWM-1:0] lit_o // generator lit level
);

  logic [`LFDA_PWM_W-1:0] frame_q;
  logic [`LFDA_NPWM-1:0] lit_q;

  // lit for steps 0..duty, i.e. duty plus one steps of the frame
  function automatic logic step_lit(input logic [`LFDA_PWM_W-1:0] step,
                                    input logic [`LFDA_PWM_W-1:0] duty);
    step_lit = (step <= duty);
  endfunction

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      frame_q <= `LFDA_PWM_ZERO;
    else if (clk_en_i)
      frame_q <= frame_q + `LFDA_PWM_ONE;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      lit_q <= '0;
    else if (clk_en_i)
    begin
      for (int g = 0; g < `LFDA_NPWM; g++)
        lit_q[g] <= step_lit(frame_q, duty_i[g]);
    end
  end

  assign lit_o = lit_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_frame_start_lit;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && frame_q == `LFDA_PWM_ZERO) |=> (&lit_q);
  endproperty
  a_frame_start_lit: assert property (p_frame_start_lit)
    else $error("generator dark at frame step zero");

  property p_full_duty_lit;
    @(posedge clk_i) disable iff (!reset_n_i)
    (clk_en_i && duty_i[0] == `LFDA_PWM_MAX) |=> lit_q[0];
  endproperty
  a_full_duty_lit: assert property (p_full_duty_lit)
    else $error("full duty generator went dark");
endmodule

//--- dv/lfda_host_model.sv
// host side model of the error line seen by the controller
`timescale 1ns/1ps
module lfda_host_model (
  input wire logic err_i, // device drive level
  input wire logic err_oe_i, // device pulls the line
  output logic err_line_o // resolved error line
);
  // pull-up holds the line high once the device releases it
  assign err_line_o = err_oe_i ? err_i : 1'b1;
endmodule

//--- dv/lfda_top_tb.sv
// self-checking testbench of the led fault detect and aggregate block
`timescale 1ns/1ps
`include "lfda_regs.svh"
module lfda_top_tb;
  logic clk_i;
  logic reset_n_i;
  logic clk_en_i;
  lfda_pkg::lfda_mask_t masks_i;
  lfda_pkg::lfda_pwm_cfg_t pwm_cfg_i;
  logic [`LFDA_NCH-1:0] rail_cmp_i;
  logic [`LFDA_NCH-1:0] gnd_cmp_i;
  logic [`LFDA_NCH-1:0] open_result_i;
  logic [`LFDA_NCH-1:0] adjacent_result_i;
  lfda_pkg::lfda_fault_in_t fault_i;
  lfda_pkg::lfda_cmd_req_t cmd_i;
  logic [`LFDA_NCH-1:0] led_on_o;
  logic rd_valid_o;
  logic [`LFDA_RD_W-1:0] rd_data_o;
  logic err_o;
  logic err_oe_o;
  logic err_line;
  int n_errors;
  int n_compared;
  int i;
  int c;
  int cnt [12] = '{default: 0};
  logic [6:0] flt_tab [8] = '{7'h41, 7'h21, 7'h11, 7'h09, 7'h05, 7'h00, 7'h03, 7'h02};
  logic [11:0] st_tab [8] = '{12'h001, 12'h004, 12'h008, 12'h010, 12'h020, 12'h000, 12'h000,
    12'h000};
  logic lvl_tab [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [9:0] duty_tab [6] = '{10'h37F, 10'h2FF, 10'h27F, 10'h07F, 10'h0FF, 10'h3FF};
  logic [11:0] on_tab [12] = '{12'h380, 12'h300, 12'h280, 12'h080, 12'h100, 12'h400, 12'h400,
    12'h000, 12'h000, 12'h000, 12'h000, 12'h000};

  lfda_top dut_u (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .masks_i(masks_i),
    .pwm_cfg_i(pwm_cfg_i),
    .rail_cmp_i(rail_cmp_i),
    .gnd_cmp_i(gnd_cmp_i),
    .open_result_i(open_result_i),
    .adjacent_result_i(adjacent_result_i),
    .fault_i(fault_i),
    .cmd_i(cmd_i),
    .led_on_o(led_on_o),
    .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o),
    .err_o(err_o),
    .err_oe_o(err_oe_o)
  );

  lfda_host_model host_u (
    .err_i(err_o),
    .err_oe_i(err_oe_o),
    .err_line_o(err_line)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({11'h000, got}, {11'h000, exp});
  endtask

  // one-cycle command pulse, taken at the second edge
  task automatic issue(input lfda_pkg::lfda_cmd_t code);
    @(posedge clk_i);
    cmd_i <= '{valid: 1'b1, code: code};
    @(posedge clk_i);
    cmd_i <= '{valid: 1'b0, code: code};
  endtask

  task automatic read_cmd(input lfda_pkg::lfda_cmd_t code, input logic [11:0] exp);
    issue(code);
    #1;
    chk_bit(rd_valid_o, 1'b1);
    chk_word(rd_data_o, exp);
  endtask

  // error line needs one edge after the clear is taken
  task automatic clear_all();
    issue(lfda_pkg::LFDA_CLR_STATUS);
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic test_done();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_errors = 0;
    n_compared = 0;
    clk_en_i = 1'b1;
    masks_i = '0;
    pwm_cfg_i = '0;
    rail_cmp_i = '0;
    gnd_cmp_i = '0;
    open_result_i = '0;
    adjacent_result_i = '0;
    fault_i = 7'h01;
    cmd_i = '0;
    reset_n_i = 1'b0;
    for (i = 0; i < 12; i++)
      pwm_cfg_i.sel[i] = 3'h7;
    repeat (6) @(posedge clk_i);
    #1 chk_bit(err_line, 1'b0);
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    read_cmd(lfda_pkg::LFDA_RD_STATUS, 12'h040);
    chk_bit(err_line, 1'b0);
    clear_all();
    chk_bit(err_line, 1'b1);
    // each fault source alone, then released and cleared
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      fault_i <= flt_tab[i];
      repeat (3) @(posedge clk_i);
      #1 chk_bit(err_line, lvl_tab[i]);
      read_cmd(lfda_pkg::LFDA_RD_STATUS, st_tab[i]);
      read_cmd(lfda_pkg::LFDA_RD_CURRENT_REFERENCE_PIN, {10'h000, flt_tab[i][1:0]});
      @(posedge clk_i);
      fault_i <= 7'h01;
      clear_all();
      chk_bit(err_line, 1'b1);
    end
    // rail and ground detection with masked channels
    @(posedge clk_i);
    masks_i <= '{out_en: 12'hFFD, rail_chan: 12'hFFB, rail_glob: 1'b1, gnd_chan: 12'hFEF,
      gnd_glob: 1'b0};
    for (i = 0; i < 3; i++)
      pwm_cfg_i.sel[i] <= 3'h0;
    rail_cmp_i <= 12'hFFF;
    repeat (5) @(posedge clk_i);
    masks_i.gnd_glob <= 1'b1;
    gnd_cmp_i <= 12'hFFF;
    repeat (35) @(posedge clk_i);
    read_cmd(lfda_pkg::LFDA_RD_RAIL, 12'h000);
    repeat (30) @(posedge clk_i);
    read_cmd(lfda_pkg::LFDA_RD_RAIL, 12'h001);
    read_cmd(lfda_pkg::LFDA_RD_GND, 12'hFEA);
    read_cmd(lfda_pkg::LFDA_RD_STATUS, 12'h002);
    chk_bit(err_line, 1'b0);
    @(posedge clk_i);
    rail_cmp_i <= '0;
    gnd_cmp_i <= '0;
    repeat (60) @(posedge clk_i);
    read_cmd(lfda_pkg::LFDA_RD_RAIL, 12'h001);
    read_cmd(lfda_pkg::LFDA_RD_GND, 12'hFEA);
    // reset in mid-run drops results and raises the reset event
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    read_cmd(lfda_pkg::LFDA_RD_RAIL, 12'h000);
    read_cmd(lfda_pkg::LFDA_RD_STATUS, 12'h040);
    chk_bit(err_line, 1'b0);
    // global masks off stop all detection
    @(posedge clk_i);
    masks_i.rail_glob <= 1'b0;
    masks_i.gnd_glob <= 1'b0;
    clear_all();
    @(posedge clk_i);
    rail_cmp_i <= 12'hFFF;
    gnd_cmp_i <= 12'hFFF;
    repeat (60) @(posedge clk_i);
    read_cmd(lfda_pkg::LFDA_RD_RAIL, 12'h000);
    read_cmd(lfda_pkg::LFDA_RD_GND, 12'h000);
    read_cmd(lfda_pkg::LFDA_RD_STATUS, 12'h000);
    chk_bit(err_line, 1'b1);
    // other result groups, unknown code, frozen clock
    @(posedge clk_i);
    rail_cmp_i <= '0;
    gnd_cmp_i <= '0;
    open_result_i <= 12'hA5C;
    adjacent_result_i <= 12'h3C1;
    read_cmd(lfda_pkg::lfda_cmd_t'(3'h7), 12'h000);
    read_cmd(lfda_pkg::LFDA_RD_OPEN, 12'hA5C);
    read_cmd(lfda_pkg::LFDA_RD_ADJ, 12'h3C1);
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    issue(lfda_pkg::LFDA_RD_STATUS);
    #1 chk_bit(rd_valid_o, 1'b0);
    @(posedge clk_i);
    clk_en_i <= 1'b1;
    // lit time per frame for every select code
    masks_i <= '{out_en: 12'hEFF, rail_chan: 12'hFFF, rail_glob: 1'b0, gnd_chan: 12'hFFF,
      gnd_glob: 1'b0};
    for (i = 0; i < 12; i++)
      pwm_cfg_i.sel[i] <= (i < 6) ? 3'(i + 1) : ((i == 6 || i == 8) ? 3'h0 : 3'h7);
    for (i = 0; i < 6; i++)
      pwm_cfg_i.duty[i] <= duty_tab[i];
    repeat (1100) @(posedge clk_i);
    for (c = 0; c < 1024; c++)
    begin
      @(posedge clk_i);
      #1;
      for (i = 0; i < 12; i++)
        cnt[i] += int'(led_on_o[i]);
    end
    for (i = 0; i < 12; i++)
      chk_word(12'(cnt[i]), on_tab[i]);
    test_done();
  end
endmodule
